// file: logic/interval_timer_12bit.sv
// Twelve-bit interval timer with clock gate, oscillator select and a periodic interrupt
// How it works
// R1: Supply gate off holds timer in reset
// R2: Gate off: control writes ignored, defaults read
// R3: Software writes zero to enable bits 1-3
// R4: Oscillator select bit enables low-speed clock
// R5: Select oscillator and stabilise before gate on
// R6: Never clear oscillator select while running
// R7: Other speed mode bits written as zero
// R8: Control word: run bit 15, compare 11:0
// R9: Run low stops and clears counter
// R10: Period is count clock times compare plus one
// R11: Match clears counter and raises interrupt
// R12: Run readback updates one count clock later
// R13: Compare changes only while run is low
// R14: Mask interrupt before stop, clear flag first
// R15: Wait one count clock before standby
// R16: Control written whole, others as bytes
// R17: Interrupt flag sticky until software clears
`timescale 1ns/1ps
`include "itimer_regs.svh"

module interval_timer_12bit (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             irq_o,
    output logic             interval_interrupt_o
);

    itimer_pkg::state_s s_q;
    itimer_pkg::state_s s_d;
    logic [1:0]         rst_sync_q;
    logic               rst_n;
    logic               tick;
    logic               match;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Release goes through two flops so it leaves glitch free
    // Kept outside the state struct: it lives in the pin's own reset domain
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Count clock and match
    // ------------------------------------------------------------
    // R4: count clock only when oscillator selected
    assign tick  = s_q.smc[`SMC_OSC_SEL_BIT] && (s_q.div_cnt == 13'(`OSC_DIV_CYCLES - 1));
    // R11: match of counter against compare value
    assign match = s_q.run_seen && tick && (s_q.count == s_q.itc[`CMP_MSB:0]);

    // Interrupt level stays high while the single status flag is set and irq_mask is 1
    assign irq_o                = s_q.irq_flag && s_q.irq_mask;
    assign interval_interrupt_o = match;
    assign rdata_o              = s_q.rdata;

    function automatic logic hit(input logic [19:0] a, input logic [19:0] b);
        hit = (a == b);
    endfunction : hit

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic gate_on;
        gate_on = s_q.pcg1[`PCG1_CLK_EN_BIT];
        s_d          = s_q;
        s_d.rdata    = 16'h0000;

        // Divider runs free so count clock edges are regular
        if (s_q.div_cnt == 13'(`OSC_DIV_CYCLES - 1)) begin
            s_d.div_cnt = 13'h0000;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 13'h0001;
        end

        // R9: stop clears the counter; R10: wrap after compare
        if (!s_q.run_seen) begin
            s_d.count = 12'h000;
        end else if (tick) begin
            if (match) begin
                s_d.count = 12'h000;
            end else begin
                s_d.count = s_q.count + 12'h001;
            end
        end

        // R12: run bit reaches the counter on the next count clock
        if (tick) begin
            s_d.run_seen = s_q.itc[`ITC_RUN_BIT];
        end

        // Register writes
        if (wr_i) begin
            if (hit(addr_i, `ADDR_PCG1)) begin
                s_d.pcg1 = wdata_i[7:0] & `PCG1_WMASK;
            end
            if (hit(addr_i, `ADDR_SMC)) begin
                s_d.smc = wdata_i[7:0] & `SMC_WMASK;
            end
            // R2: control writes only land while supply is on
            if (hit(addr_i, `ADDR_ITC) && gate_on) begin
                s_d.itc = {wdata_i[15], 3'h0, wdata_i[11:0]};
            end
            if (hit(addr_i, `ADDR_IRQ_MASK)) begin
                s_d.irq_mask = wdata_i[0];
            end
        end

        // Reads; status read clears flag but a new match wins
        if (rd_i) begin
            case (1'b1)
                hit(addr_i, `ADDR_PCG1):       s_d.rdata = {8'h00, s_q.pcg1};
                hit(addr_i, `ADDR_SMC):        s_d.rdata = {8'h00, s_q.smc};
                // R12: readback shows the applied run bit
                hit(addr_i, `ADDR_ITC): begin
                    // R2: gated control reads back its default, even in the cycle the gate drops
                    if (gate_on) begin
                        s_d.rdata = {s_q.run_seen, 3'h0, s_q.itc[`CMP_MSB:0]};
                    end else begin
                        s_d.rdata = `ITC_RESET;
                    end
                end
                hit(addr_i, `ADDR_IRQ_MASK):   s_d.rdata = {15'h0000, s_q.irq_mask};
                hit(addr_i, `ADDR_IRQ_STATUS): begin
                    s_d.rdata    = {15'h0000, s_q.irq_flag};
                    s_d.irq_flag = 1'b0;
                end
                default:                       s_d.rdata = 16'h0000;
            endcase
        end
        // R17: sticky flag, set beats clear
        if (match) begin
            s_d.irq_flag = 1'b1;
        end

        // R1: gated supply holds timer in reset
        case (s_q.supply)
            itimer_pkg::ST_GATED: begin
                // Leaving the gate must not clobber a control write of the same cycle
                if (gate_on) begin
                    s_d.supply = itimer_pkg::ST_LIVE;
                end else begin
                    s_d.itc      = `ITC_RESET;
                    s_d.run_seen = 1'b0;
                    s_d.count    = 12'h000;
                end
            end
            itimer_pkg::ST_LIVE: begin
                if (!gate_on) begin
                    s_d.supply   = itimer_pkg::ST_GATED;
                    s_d.itc      = `ITC_RESET;
                    s_d.run_seen = 1'b0;
                    s_d.count    = 12'h000;
                end
            end
            default: s_d.supply = itimer_pkg::ST_GATED;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // R8: control word resets to full-scale compare, run low
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q.supply   <= itimer_pkg::ST_GATED;
            s_q.pcg1     <= `PCG1_RESET;
            s_q.smc      <= `SMC_RESET;
            s_q.itc      <= `ITC_RESET;
            s_q.run_seen <= 1'b0;
            s_q.div_cnt  <= 13'h0000;
            s_q.count    <= 12'h000;
            s_q.irq_flag <= 1'b0;
            s_q.irq_mask <= 1'b1;
            s_q.rdata    <= 16'h0000;
        end else begin
            s_q.supply   <= s_d.supply;
            s_q.pcg1     <= s_d.pcg1;
            s_q.smc      <= s_d.smc;
            s_q.itc      <= s_d.itc;
            s_q.run_seen <= s_d.run_seen;
            s_q.div_cnt  <= s_d.div_cnt;
            s_q.count    <= s_d.count;
            s_q.irq_flag <= s_d.irq_flag;
            s_q.irq_mask <= s_d.irq_mask;
            s_q.rdata    <= s_d.rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // R1: gate off holds reset
    a_gate_holds_reset: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
        !s_q.pcg1[`PCG1_CLK_EN_BIT] |=> (s_q.count == 12'h000) && !s_q.run_seen)
        else $error("timer not held in reset while supply gated");

    // R2: gated writes dropped
    a_gated_write_lost: assert property (@(posedge clk_i) disable iff (!rst_n) // R2
        (wr_i && addr_i == `ADDR_ITC && !s_q.pcg1[`PCG1_CLK_EN_BIT]) |=> s_q.itc == `ITC_RESET)
        else $error("control write landed while supply gated");

    // R2: gated reads give default
    a_gated_read_default: assert property (@(posedge clk_i) disable iff (!rst_n) // R2
        (rd_i && addr_i == `ADDR_ITC && !s_q.pcg1[`PCG1_CLK_EN_BIT]) |=> rdata_o == `ITC_RESET)
        else $error("control read not default while supply gated");

    // R2: supplied writes land
    a_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n) // R2
        (wr_i && addr_i == `ADDR_ITC && s_q.pcg1[`PCG1_CLK_EN_BIT])
        |=> s_q.itc == {$past(wdata_i[15]), 3'h0, $past(wdata_i[11:0])})
        else $error("control write lost while supply on");

    // R4: select gates count clock
    a_osc_needed: assert property (@(posedge clk_i) disable iff (!rst_n) // R4
        !s_q.smc[`SMC_OSC_SEL_BIT] |-> !tick)
        else $error("count clock ran without oscillator select");

    // R4: count clock one cycle wide
    a_tick_single: assert property (@(posedge clk_i) disable iff (!rst_n) // R4
        tick |=> !tick)
        else $error("count clock strobe longer than one cycle");

    // R8: fixed-zero control bits
    a_ctrl_zero_bits: assert property (@(posedge clk_i) disable iff (!rst_n) // R8
        s_q.itc[14:12] == 3'h0)
        else $error("control bits 14..12 not zero");

    // R8: readback zero bits
    a_ctrl_readback: assert property (@(posedge clk_i) disable iff (!rst_n) // R8
        (rd_i && addr_i == `ADDR_ITC) |=> rdata_o[14:12] == 3'h0)
        else $error("control readback bits 14..12 not zero");

    // R9: stop clears counter
    a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_n) // R9
        (!s_q.run_seen && s_q.pcg1[`PCG1_CLK_EN_BIT]) ##1 !s_q.run_seen |-> s_q.count == 12'h000)
        else $error("counter not cleared while stopped");

    // R9: no request while stopped
    a_stopped_no_pulse: assert property (@(posedge clk_i) disable iff (!rst_n) // R9
        !s_q.run_seen |-> !interval_interrupt_o)
        else $error("interval request while stopped");

    // R10: counter holds between ticks
    a_count_holds: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
        (s_q.run_seen && !tick && s_q.pcg1[`PCG1_CLK_EN_BIT]) |=> $stable(s_q.count))
        else $error("counter moved without a count clock");

    // R10: counter steps by one
    a_count_steps: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
        (tick && !match && s_q.run_seen && s_q.pcg1[`PCG1_CLK_EN_BIT])
        |=> s_q.count == $past(s_q.count) + 12'h001)
        else $error("counter did not step on a count clock");

    // R11: match wraps and flags
    a_match_wrap: assert property (@(posedge clk_i) disable iff (!rst_n) // R11
        match && s_q.pcg1[`PCG1_CLK_EN_BIT] |=> s_q.count == 12'h000 && s_q.irq_flag)
        else $error("match did not wrap counter and flag request");

    // R11: request is one pulse
    a_pulse_single: assert property (@(posedge clk_i) disable iff (!rst_n) // R11
        interval_interrupt_o |=> !interval_interrupt_o)
        else $error("interval request longer than one cycle");

    // R12: run applied on tick
    a_run_applied_tick: assert property (@(posedge clk_i) disable iff (!rst_n) // R12
        $changed(s_q.run_seen) && s_q.pcg1[`PCG1_CLK_EN_BIT] && $past(s_q.pcg1[`PCG1_CLK_EN_BIT]) |-> $past(tick))
        else $error("run bit applied off a count clock edge");

    // R17: flag sticky until read
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n) // R17
        s_q.irq_flag && !(rd_i && addr_i == `ADDR_IRQ_STATUS) |=> s_q.irq_flag)
        else $error("interrupt flag dropped without a status read");

    // R17: status read returns flag
    a_status_readback: assert property (@(posedge clk_i) disable iff (!rst_n) // R17
        (rd_i && addr_i == `ADDR_IRQ_STATUS) |=> rdata_o == {15'h0000, $past(s_q.irq_flag)})
        else $error("status read did not return the flag");

    // R17: status read clears flag
    a_status_clears: assert property (@(posedge clk_i) disable iff (!rst_n) // R17
        (rd_i && addr_i == `ADDR_IRQ_STATUS && !match) |=> !s_q.irq_flag)
        else $error("status read did not clear the flag");

endmodule : interval_timer_12bit

// file: pkg/itimer_regs.svh
// Register offsets, field positions, reset values and timing counts of the interval timer
`ifndef ITIMER_REGS_SVH
`define ITIMER_REGS_SVH

`define ADDR_PCG1         20'hF007A
`define ADDR_SMC          20'hF00F3
`define ADDR_ITC          20'hFFF90
`define ADDR_IRQ_STATUS   20'hFFF94
`define ADDR_IRQ_MASK     20'hFFF96

`define PCG1_CLK_EN_BIT   7
`define PCG1_WMASK        8'hF1
`define PCG1_RESET        8'h00
`define SMC_OSC_SEL_BIT   4
`define SMC_WMASK         8'h10
`define SMC_RESET         8'h00
`define ITC_RUN_BIT       15
`define ITC_RESET         16'h0FFF
`define CMP_MSB           11
`define IRQ_MASK_RESET    8'h01

// Low-speed oscillator period in ns and the divider it implies at 100 MHz
`define CLK_PERIOD_NS     10
`define OSC_PERIOD_NS     66667
`define OSC_DIV_CYCLES    (`OSC_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// file: pkg/itimer_pkg.sv
// Types shared by the interval timer design
package itimer_pkg;

    typedef enum logic [1:0] {
        ST_GATED = 2'b01,
        ST_LIVE  = 2'b10
    } supply_e;

    typedef struct packed {
        supply_e     supply;
        logic [7:0]  pcg1;
        logic [7:0]  smc;
        logic [15:0] itc;
        logic        run_seen;
        logic [12:0] div_cnt;
        logic [11:0] count;
        logic        irq_flag;
        logic        irq_mask;
        logic [15:0] rdata;
    } state_s;

endpackage : itimer_pkg

// file: verif/interval_timer_12bit_tb.sv
// Self-checking bench for the interval timer: register access, gating, periodic interrupt
`timescale 1ns/1ps
`include "itimer_regs.svh"

module interval_timer_12bit_tb;
    logic        clk_i;
    logic        nrst_i;
    logic [19:0] addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic        irq_o;
    logic        interval_interrupt_o;
    int          err_total;
    int          check_count;
    int          n;
    logic [15:0] v;

    interval_timer_12bit dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .interval_interrupt_o(interval_interrupt_o));

    // ----------------------------------------
    // Bus and comparison helpers
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe, released at the edge that takes it
    task automatic bus_wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic bus_rd(input logic [19:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : bus_rd

    // Bounded wait for the match pulse; returns the number of edges that passed
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            #1 cnt++;
        end while (interval_interrupt_o !== 1'b1 && cnt < 30000);
        if (cnt >= 30000) chk("pulse_timeout", 16'h0001, 16'h0000);
    endtask : wait_pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        bus_rd(`ADDR_PCG1, v);       chk("gate_rst", v, 16'h0000);
        bus_rd(`ADDR_SMC, v);        chk("smc_rst", v, 16'h0000);
        bus_rd(`ADDR_ITC, v);        chk("itc_rst", v, 16'h0FFF);
        bus_rd(`ADDR_IRQ_STATUS, v); chk("stat_rst", v, 16'h0000);
        bus_rd(`ADDR_IRQ_MASK, v);   chk("mask_rst", v, 16'h0001);
        bus_rd(20'hFFF00, v);        chk("unmapped", v, 16'h0000);
        $display("test reset values done");
    endtask : t_reset_values

    // Control writes are dropped while the supply gate is off; fixed-zero bits stay zero
    task automatic t_gated_writes;
        bus_wr(`ADDR_ITC, 16'h8001);
        bus_rd(`ADDR_ITC, v);        chk("itc_gated", v, 16'h0FFF);
        bus_wr(`ADDR_SMC, 16'h00FF);
        bus_rd(`ADDR_SMC, v);        chk("smc_bits", v, 16'h0010);
        bus_wr(`ADDR_PCG1, 16'h000E);
        bus_rd(`ADDR_PCG1, v);       chk("gate_bits", v, 16'h0000);
        $display("test gated writes done");
    endtask : t_gated_writes

    // Compare 1 gives the shortest legal period: two count clocks between matches
    task automatic t_run_period;
        repeat (8) @(posedge clk_i);
        bus_wr(`ADDR_PCG1, 16'h0080);
        bus_wr(`ADDR_ITC, 16'h8001);
        bus_rd(`ADDR_ITC, v);        chk("run_late", v, 16'h0001);
        wait_pulse(n);
        bus_rd(`ADDR_ITC, v);        chk("run_seen", v, 16'h8001);
        // The read above ate edges, so time a full pulse-to-pulse span
        wait_pulse(n);
        wait_pulse(n);
        chk("period", 16'(n), 16'(2 * `OSC_DIV_CYCLES));
        @(posedge clk_i);
        #1 chk("irq_set", {15'h0, irq_o}, 16'h0001);
        bus_rd(`ADDR_IRQ_STATUS, v); chk("stat_set", v, 16'h0001);
        chk("irq_clr", {15'h0, irq_o}, 16'h0000);
        $display("test run period done");
    endtask : t_run_period

    // Masked flag still sets and holds until read; stop then gate off restores defaults
    task automatic t_mask_stop;
        bus_wr(`ADDR_IRQ_MASK, 16'h0000);
        wait_pulse(n);
        @(posedge clk_i);
        #1 chk("irq_masked", {15'h0, irq_o}, 16'h0000);
        bus_wr(`ADDR_IRQ_MASK, 16'h0001);
        #1 chk("irq_unmask", {15'h0, irq_o}, 16'h0001);
        bus_rd(`ADDR_IRQ_STATUS, v); chk("stat_hold", v, 16'h0001);
        bus_wr(`ADDR_IRQ_MASK, 16'h0000);
        bus_wr(`ADDR_ITC, 16'h0001);
        bus_wr(`ADDR_PCG1, 16'h0000);
        bus_rd(`ADDR_ITC, v);        chk("itc_off", v, 16'h0FFF);
        $display("test mask and stop done");
    endtask : t_mask_stop

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // Whole run is about 60k cycles; 80k leaves margin and stays inside the budget
    initial begin
        #800_000;
        err_total++;
        conclude();
    end

    initial begin
        err_total   = 0;
        check_count = 0;
        nrst_i      = 1'b0;
        addr_i      = 20'h00000;
        wdata_i     = 16'h0000;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset_values();
        t_gated_writes();
        t_run_period();
        t_mask_stop();
        conclude();
    end
endmodule : interval_timer_12bit_tb
